// [hw/shs_hw_stacks.sv]
// return-address and status stacks of the program sequencer, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "shs_stack_map.svh"

// Notes on behaviour
// - return stack holds thirty 32-bit entries, outside the memory map.
// - return and status stacks are dedicated hardware used by flow changes.
// - full flag bit 21 is high while all entries occupied, drops on pop.
// - empty flag bit 22 is high while no entries occupied, drops on push.
// - overflow interrupt raised once 29 of 30 return entries are filled.
// - push return address on call or vector branch, loop top on loop start.
// - pop on return from subroutine, return from interrupt, loop end.
// - program counter holds 24-bit address of the next executed instruction.
// - software reads and writes top entry without moving the pointer.
// - empty stack reads top as 0x7FFFFFFF and ignores top writes.
// - pointer reads 0 empty, 1 to 30 with entries, 31 overflowed.
// - pointer write applies one cycle later, keeping the oldest entries.
// - pointer writes are ignored while the return stack is overflowed.
// - top-entry write beats a sequencer push in the same cycle.
// - vector branch except emulation and reset pushes status; 15 deep.
// - a status push clears the mode bits selected by the clear mask.
// - status stack pops on return from interrupt and clear-irq jump.
// - status pointer moves only on push or pop, never register access.
// - a register reaches the mode value saved in the top status entry.
// - status overflow bit 23 set on push to full stack, sticky.
// - status empty bit 24 is high while no entries, drops on push.
module shs_hw_stacks
	import shs_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	input  wire shs_seq_req_t         seq_req,
	input  wire logic [31:0]          arith_status_x,
	input  wire logic [31:0]          arith_status_y,
	output logic [`SHS_PC_W-1:0]      program_counter,
	output logic [31:0]               core_mode_reg,
	output shs_restore_t              status_restore,
	output logic                      stack_overflow_irq,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);

	////////////////////////////////////////////////////////////////////////////////

	function automatic shs_reg_t reg_decode(input logic [11:0] a);
		case (a)
			`SHS_OFF_RET_TOP:    reg_decode = SHS_R_TOP;
			`SHS_OFF_RET_PTR:    reg_decode = SHS_R_PTR;
			`SHS_OFF_STICKY:     reg_decode = SHS_R_STKY;
			`SHS_OFF_MODE:       reg_decode = SHS_R_MODE;
			`SHS_OFF_MODE_MASK:  reg_decode = SHS_R_MASK;
			`SHS_OFF_SAVED_MODE: reg_decode = SHS_R_SAVED;
			`SHS_OFF_PC:         reg_decode = SHS_R_PC;
			default:             reg_decode = SHS_R_NONE;
		endcase
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge_bytes[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	endfunction

	// index of the top entry; overflow keeps the last real slot on top
	function automatic logic [4:0] rs_top_idx(input logic [4:0] p);
		rs_top_idx = (p == `SHS_RS_OVF) ? 5'(`SHS_RS_DEPTH - 1) : 5'(p - 5'h01);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic       rst_sync_q;
	logic       rst_sync2_q;
	shs_state_t s_q;
	shs_state_t s_d;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q  <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync_q  <= 1'b1;
			rst_sync2_q <= rst_sync_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	logic        wr_fire;
	logic        rd_fire;
	shs_reg_t    wr_reg;
	shs_reg_t    rd_reg;
	logic [31:0] wr_val;
	logic        rs_empty;
	logic        rs_ovf;
	logic [4:0]  rs_top;
	logic [3:0]  ss_top;
	logic        ss_push;
	logic        ss_pop;
	logic [31:0] sticky_view;
	logic [31:0] rd_val;
	logic        top_wr;

	always_comb begin
		wr_fire  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
		rd_fire  = s_axi_arvalid && !s_q.rvalid;
		wr_reg   = reg_decode(s_q.aw_addr);
		rd_reg   = reg_decode(s_axi_araddr[11:0]);
		rs_empty = (s_q.rs_ptr == 5'h00);
		rs_ovf   = (s_q.rs_ptr == `SHS_RS_OVF);
		rs_top   = rs_top_idx(s_q.rs_ptr);
		ss_top   = 4'(s_q.ss_ptr - 4'h1);
		top_wr   = wr_fire && (wr_reg == SHS_R_TOP);
		// vectored interrupts other than emulation and reset, and explicit status pushes, save status
		ss_push  = (seq_req.ivt_branch && !seq_req.irq_exempt) || seq_req.sts_push;
		ss_pop   = (seq_req.return_from_irq && !seq_req.irq_exempt)
			|| seq_req.clear_irq_option || seq_req.sts_pop;
		sticky_view = 32'h00000000;
		sticky_view[`SHS_BIT_RS_FULL]  = (s_q.rs_ptr >= `SHS_RS_FULL);
		sticky_view[`SHS_BIT_RS_EMPTY] = rs_empty;
		sticky_view[`SHS_BIT_SS_OVF]   = s_q.ss_ovf;
		sticky_view[`SHS_BIT_SS_EMPTY] = (s_q.ss_ptr == 4'h0);
		case (rd_reg)
			SHS_R_TOP:   rd_val = rs_empty ? `SHS_RS_EMPTY_READ : s_q.rs_mem[rs_top];
			SHS_R_PTR:   rd_val = {27'h0000000, s_q.rs_ptr};
			SHS_R_STKY:  rd_val = sticky_view;
			SHS_R_MODE:  rd_val = s_q.mode;
			SHS_R_MASK:  rd_val = s_q.mask;
			SHS_R_SAVED: rd_val = (s_q.ss_ptr == 4'h0) ? 32'h00000000
				: s_q.ss_mem[ss_top].mode;
			SHS_R_PC:    rd_val = {8'h00, s_q.pc};
			default:     rd_val = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_d = s_q;
		s_d.rst_out.valid = 1'b0;
		wr_val = 32'h00000000;

		// bus channels: one write and one read outstanding at a time
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr[11:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd_val;
			s_d.rresp  = (rd_reg == SHS_R_NONE) ? `SHS_RESP_SLVERR : `SHS_RESP_OKAY;
		end

		// program counter is the last pipeline stage
		if (seq_req.pc_load) begin
			s_d.pc = seq_req.next_pc;
		end

		// return stack; a pending pointer write owns the cycle it lands in
		if (s_q.ptr_pend) begin
			s_d.rs_ptr   = s_q.ptr_val;
			s_d.ptr_pend = 1'b0;
		end else if (top_wr) begin
			// the write wins; a coinciding push or pop is dropped
			if (!rs_empty) begin
				s_d.rs_mem[rs_top] = merge_bytes(s_q.rs_mem[rs_top], s_q.w_data,
					s_q.w_strb);
			end
		end else if (seq_req.pc_push) begin
			if (s_q.rs_ptr < `SHS_RS_FULL) begin
				s_d.rs_mem[s_q.rs_ptr] = seq_req.push_addr;
			end
			s_d.rs_ptr = rs_ovf ? `SHS_RS_OVF : 5'(s_q.rs_ptr + 5'h01);
		end else if (seq_req.pc_pop) begin
			s_d.rs_ptr = rs_empty ? 5'h00 : 5'(s_q.rs_ptr - 5'h01);
		end

		// software register writes
		if (wr_fire) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = (wr_reg == SHS_R_NONE) ? `SHS_RESP_SLVERR : `SHS_RESP_OKAY;
			case (wr_reg)
				SHS_R_PTR: begin
					wr_val = merge_bytes({27'h0000000, s_q.rs_ptr}, s_q.w_data, s_q.w_strb);
					if (!rs_ovf) begin
						s_d.ptr_pend = 1'b1;
						// depths past the last slot clamp to full
						s_d.ptr_val = (wr_val > 32'(`SHS_RS_DEPTH)) ? `SHS_RS_FULL
							: wr_val[4:0];
					end
				end
				SHS_R_STKY: begin
					// write one to clear; a same-cycle overflow below sets it again
					if (s_q.w_strb[`SHS_BIT_SS_OVF / 8] && s_q.w_data[`SHS_BIT_SS_OVF]) begin
						s_d.ss_ovf = 1'b0;
					end
				end
				SHS_R_MODE: s_d.mode = merge_bytes(s_q.mode, s_q.w_data, s_q.w_strb);
				SHS_R_MASK: s_d.mask = merge_bytes(s_q.mask, s_q.w_data, s_q.w_strb);
				SHS_R_SAVED: begin
					if (s_q.ss_ptr != 4'h0) begin
						s_d.ss_mem[ss_top].mode = merge_bytes(s_q.ss_mem[ss_top].mode,
							s_q.w_data, s_q.w_strb);
					end
				end
				default: begin
				end
			endcase
		end

		// status stack; push takes priority over a pop in the same cycle
		if (ss_push) begin
			if (s_q.ss_ptr == `SHS_SS_FULL) begin
				s_d.ss_ovf = 1'b1;
			end else begin
				s_d.ss_mem[s_q.ss_ptr] = '{mode: s_q.mode, ax: arith_status_x,
					ay: arith_status_y};
				s_d.ss_ptr = 4'(s_q.ss_ptr + 4'h1);
				s_d.mode   = s_d.mode & ~s_q.mask;
			end
		end else if (ss_pop && s_q.ss_ptr != 4'h0) begin
			s_d.ss_ptr  = ss_top;
			s_d.mode    = s_q.ss_mem[ss_top].mode;
			s_d.rst_out = '{valid: 1'b1, mode: s_q.ss_mem[ss_top].mode,
				ax: s_q.ss_mem[ss_top].ax, ay: s_q.ss_mem[ss_top].ay};
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync2_q) begin
		if (!rst_sync2_q) begin
			s_q      <= '0;
			s_q.mode <= `SHS_MODE_RST;
			s_q.mask <= `SHS_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// level, held while the almost-full depth or more is reached
	assign stack_overflow_irq = (s_q.rs_ptr >= `SHS_RS_WARN);
	assign program_counter    = s_q.pc;
	assign core_mode_reg      = s_q.mode;
	assign status_restore     = s_q.rst_out;
	assign s_axi_awready      = !s_q.aw_have && !s_q.bvalid;
	assign s_axi_wready       = !s_q.w_have && !s_q.bvalid;
	assign s_axi_bvalid       = s_q.bvalid;
	assign s_axi_bresp        = s_q.bresp;
	assign s_axi_arready      = !s_q.rvalid;
	assign s_axi_rvalid       = s_q.rvalid;
	assign s_axi_rdata        = s_q.rdata;
	assign s_axi_rresp        = s_q.rresp;

endmodule
`default_nettype wire

// [hw/shs_stack_map.svh]
// offsets, field positions, reset values and sizes of the sequencer stacks
`ifndef SHS_STACK_MAP_SVH
`define SHS_STACK_MAP_SVH

`define SHS_OFF_RET_TOP        12'h000
`define SHS_OFF_RET_PTR        12'h004
`define SHS_OFF_STICKY         12'h008
`define SHS_OFF_MODE           12'h00C
`define SHS_OFF_MODE_MASK      12'h010
`define SHS_OFF_SAVED_MODE     12'h014
`define SHS_OFF_PC             12'h018

`define SHS_BIT_RS_FULL        21
`define SHS_BIT_RS_EMPTY       22
`define SHS_BIT_SS_OVF         23
`define SHS_BIT_SS_EMPTY       24

`define SHS_RS_DEPTH           30
`define SHS_RS_WARN            5'h1D
`define SHS_RS_FULL            5'h1E
`define SHS_RS_OVF             5'h1F
`define SHS_SS_DEPTH           15
`define SHS_SS_FULL            4'hF
`define SHS_PC_W               24

`define SHS_RS_EMPTY_READ      32'h7FFFFFFF
`define SHS_MODE_RST           32'h00000000
`define SHS_MASK_RST           32'h00000000
`define SHS_RESP_OKAY          2'h0
`define SHS_RESP_SLVERR        2'h2

`endif

// [hw/shs_pkg.sv]
// types of the sequencer stack block
`default_nettype none
`include "shs_stack_map.svh"
package shs_pkg;

	typedef struct packed {
		logic                   pc_push;
		logic [31:0]            push_addr;
		logic                   pc_pop;
		logic                   ivt_branch;
		logic                   irq_exempt;
		logic                   return_from_irq;
		logic                   clear_irq_option;
		logic                   sts_push;
		logic                   sts_pop;
		logic                   pc_load;
		logic [`SHS_PC_W-1:0]   next_pc;
	} shs_seq_req_t;

	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] ax;
		logic [31:0] ay;
	} shs_sts_entry_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] mode;
		logic [31:0] ax;
		logic [31:0] ay;
	} shs_restore_t;

	typedef enum logic [2:0] {
		SHS_R_TOP   = 3'b000,
		SHS_R_PTR   = 3'b001,
		SHS_R_STKY  = 3'b010,
		SHS_R_MODE  = 3'b011,
		SHS_R_MASK  = 3'b100,
		SHS_R_SAVED = 3'b101,
		SHS_R_PC    = 3'b110,
		SHS_R_NONE  = 3'b111
	} shs_reg_t;

	typedef struct packed {
		logic [`SHS_RS_DEPTH-1:0][31:0]     rs_mem;
		logic [4:0]                         rs_ptr;
		logic                               ptr_pend;
		logic [4:0]                         ptr_val;
		shs_sts_entry_t [`SHS_SS_DEPTH-1:0] ss_mem;
		logic [3:0]                         ss_ptr;
		logic                               ss_ovf;
		logic [31:0]                        mode;
		logic [31:0]                        mask;
		logic [`SHS_PC_W-1:0]               pc;
		shs_restore_t                       rst_out;
		logic                               aw_have;
		logic [11:0]                        aw_addr;
		logic                               w_have;
		logic [31:0]                        w_data;
		logic [3:0]                         w_strb;
		logic                               bvalid;
		logic [1:0]                         bresp;
		logic                               rvalid;
		logic [31:0]                        rdata;
		logic [1:0]                         rresp;
	} shs_state_t;

endpackage
`default_nettype wire

// [verif/shs_seq_model.sv]
// sequencer model issuing stack requests
`timescale 1ns/1ps
`default_nettype none
module shs_seq_model
	import shs_pkg::*;
(
	input  wire logic [3:0]  cmd,
	input  wire logic [31:0] arg,
	output var shs_seq_req_t seq_req
);
	// level requests, one cycle each, as the pipeline presents them
	always_comb begin
		seq_req = '0;
		seq_req.push_addr = arg;
		seq_req.next_pc = arg[23:0];
		case (cmd)
		4'h1: seq_req.pc_push = 1'b1;
		4'h2: seq_req.pc_pop = 1'b1;
		4'h3, 4'h8: begin
			seq_req.pc_push = 1'b1;
			seq_req.ivt_branch = 1'b1;
			seq_req.irq_exempt = cmd[3];
		end
		4'h4: begin
			seq_req.pc_pop = 1'b1;
			seq_req.return_from_irq = 1'b1;
		end
		4'h5: seq_req.clear_irq_option = 1'b1;
		4'h6: seq_req.sts_push = 1'b1;
		4'h7: seq_req.sts_pop = 1'b1;
		4'h9: seq_req.pc_load = 1'b1;
		default: ;
		endcase
	end
endmodule
`default_nettype wire

// [verif/shs_hw_stacks_sva.sv]
// assertion checker of the sequencer stack block
`timescale 1ns/1ps
`default_nettype none
module shs_chk
	import shs_pkg::*;
(
	input wire logic         core_clk,
	input wire logic         rst_b,
	input wire shs_seq_req_t seq_req,
	input wire logic [31:0]  arith_status_x,
	input wire logic [23:0]  program_counter,
	input wire logic [31:0]  core_mode_reg,
	input wire shs_restore_t status_restore,
	input wire logic         s_axi_awvalid,
	input wire logic         s_axi_awready,
	input wire logic         s_axi_wvalid,
	input wire logic         s_axi_wready,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_bready,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic [3:0] ss_q;
	wire ss_psh = seq_req.sts_push | (seq_req.ivt_branch & !seq_req.irq_exempt);
	wire ss_pop = seq_req.sts_pop | seq_req.clear_irq_option
		| (seq_req.return_from_irq & !seq_req.irq_exempt);
	// shadow depth; register access never moves it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) ss_q <= 4'h0;
		else if (ss_psh) ss_q <= (ss_q == 4'hF) ? ss_q : ss_q + 4'h1;
		else if (ss_pop && ss_q != 4'h0) ss_q <= ss_q - 4'h1;
	end
	////////////////////////////////////////
	property p_rest; ss_pop && !ss_psh && ss_q != 4'h0 |=> status_restore.valid; endproperty
	a_rest: assert property (p_rest) else $error("pop gave no restore");
	property p_nrest; ss_pop && ss_q == 4'h0 |=> !status_restore.valid; endproperty
	a_nrest: assert property (p_nrest) else $error("restore from empty");
	property p_pair;
		(ss_psh && ss_q != 4'hF) ##1 (ss_pop && !ss_psh)
		|=> status_restore.ax == $past(arith_status_x, 2);
	endproperty
	a_pair: assert property (p_pair) else $error("restored ax wrong");
	property p_mode; status_restore.valid |-> core_mode_reg == status_restore.mode; endproperty
	a_mode: assert property (p_mode) else $error("mode not restored");
	property p_pcl; seq_req.pc_load |=> program_counter == $past(seq_req.next_pc); endproperty
	a_pcl: assert property (p_pcl) else $error("pc not loaded");
	property p_pch; !seq_req.pc_load |=> $stable(program_counter); endproperty
	a_pch: assert property (p_pch) else $error("pc moved");
	property p_bv;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_bv: assert property (p_bv) else $error("no write response");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bh: assert property (p_bh) else $error("bvalid dropped");
	property p_rv; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("no read data");
	property p_rh; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rh: assert property (p_rh) else $error("read taken while busy");
	property p_rhd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	a_rhd: assert property (p_rhd) else $error("rvalid dropped");
endmodule
bind shs_hw_stacks shs_chk u_chk (.core_clk, .rst_b, .seq_req, .arith_status_x,
	.program_counter, .core_mode_reg, .status_restore, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [verif/tb_shs_hw_stacks.sv]
// self-checking bench of the sequencer stack block
`timescale 1ns/1ps
`default_nettype none
`include "shs_stack_map.svh"
module tb_shs_hw_stacks
	import shs_pkg::*;
;
	localparam logic [11:0] o_top = `SHS_OFF_RET_TOP, o_ptr = `SHS_OFF_RET_PTR;
	localparam logic [11:0] o_stk = `SHS_OFF_STICKY, o_mode = `SHS_OFF_MODE;
	localparam logic [11:0] o_mask = `SHS_OFF_MODE_MASK, o_sav = `SHS_OFF_SAVED_MODE;
	logic         core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic         irq, awready, wready, bvalid, arready, rvalid;
	logic [3:0]   cmd, side;
	logic [31:0]  arg, ax, ay, awaddr, wdata, araddr, rdata, rd, m, k, n, mode;
	logic [1:0]   bresp, rresp, rs;
	logic [23:0]  pc;
	logic [31:0]  a [0:29];
	shs_seq_req_t seq_req;
	shs_restore_t rest;
	integer       seed = 32'hAC6F;
	integer       mismatches = 0;
	integer       n_tests = 0;
	integer       i;
	shs_seq_model sq (.cmd(cmd), .arg(arg), .seq_req(seq_req));
	shs_hw_stacks dut (.core_clk(core_clk), .rst_b(rst_b), .seq_req(seq_req),
		.arith_status_x(ax), .arith_status_y(ay), .program_counter(pc),
		.core_mode_reg(mode), .status_restore(rest), .stack_overflow_irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo(input int j);
		if (j == 50) begin
			chk("handshake", 1, 0);
			complete_run();
		end
	endtask
	// each channel released at its own taking edge; response accepted a cycle late
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		int j;
		bit pa, pw, ta, tw;
		@(posedge core_clk);
		awaddr <= {20'h00000, ad};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		for (j = 0; j < 50 && (pa || pw); j++) begin
			@(negedge core_clk);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge core_clk);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		tmo((pa || pw) ? 50 : 0);
		cmd <= side;
		@(posedge core_clk);
		cmd <= 4'h0;
		@(negedge core_clk);
		for (j = 0; j < 50 && !bvalid; j++) @(negedge core_clk);
		tmo(j);
		@(posedge core_clk);
		bready <= 1'b1;
		@(negedge core_clk);
		rs = bresp;
		@(posedge core_clk);
		bready <= 1'b0;
	endtask
	task automatic rd_(input logic [11:0] ad);
		int j;
		@(posedge core_clk);
		araddr <= {20'h00000, ad};
		arvalid <= 1'b1;
		@(negedge core_clk);
		for (j = 0; j < 50 && !arready; j++) @(negedge core_clk);
		tmo(j);
		@(posedge core_clk);
		arvalid <= 1'b0;
		@(negedge core_clk);
		for (j = 0; j < 50 && !rvalid; j++) @(negedge core_clk);
		tmo(j);
		// data must stand while rready is still low
		@(posedge core_clk);
		rready <= 1'b1;
		@(negedge core_clk);
		rd = rdata;
		rs = rresp;
		@(posedge core_clk);
		rready <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [11:0] ad, input logic [31:0] e);
		rd_(ad);
		chk(nm, e, rd);
	endtask
	task automatic op(input logic [3:0] c, input logic [31:0] v);
		@(posedge core_clk);
		cmd <= c;
		arg <= v;
		@(posedge core_clk);
		cmd <= 4'h0;
		@(negedge core_clk);
	endtask
	function automatic logic [31:0] flg(input int p, input int s, input bit o);
		flg = 32'h00000000;
		flg[`SHS_BIT_RS_FULL] = p >= 30;
		flg[`SHS_BIT_RS_EMPTY] = p == 0;
		flg[`SHS_BIT_SS_OVF] = o;
		flg[`SHS_BIT_SS_EMPTY] = s == 0;
	endfunction
	task automatic st(input int p, input int s, input bit o);
		rc("pointer", o_ptr, p);
		rc("flags", o_stk, flg(p, s, o));
		chk("irq", p >= 29, irq);
	endtask
	////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{cmd, side} = 8'h00;
		{arg, ax, ay, awaddr, wdata, araddr} = '0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		st(0, 0, 0);
		wr(o_top, 32'h00001234);
		chk("top wresp", 2'h0, rs);
		rc("top", o_top, 32'h7FFFFFFF);
		op(4'h2, 32'h00000000);
		st(0, 0, 0);
		op(4'h7, 32'h00000000);
		chk("empty pop", 1'b0, rest.valid);
		st(0, 0, 0);
		rd_(12'h01C);
		chk("unmapped", 2'h2, rs);
		chk("unmapped data", 32'h00000000, rd);
		wr(12'h01C, 32'hFFFFFFFF);
		chk("unmapped wresp", 2'h2, rs);
		st(0, 0, 0);
		$display("test empty done");
		for (i = 0; i < 30; i++) begin
			a[i] = $random(seed);
			op(4'h1, a[i]);
			if (i == 27 || i == 28) chk("irq", i == 28, irq);
		end
		st(30, 0, 0);
		rc("top", o_top, a[29]);
		a[29] = $random(seed);
		wr(o_top, a[29]);
		st(30, 0, 0);
		rc("top", o_top, a[29]);
		op(4'h1, 32'h00000000);
		st(31, 0, 0);
		wr(o_ptr, 32'h00000003);
		st(31, 0, 0);
		op(4'h2, 32'h00000000);
		op(4'h2, 32'h00000000);
		st(29, 0, 0);
		wr(o_ptr, 32'h00000003);
		rc("top", o_top, a[2]);
		st(3, 0, 0);
		a[2] = $random(seed);
		side = 4'h1;
		wr(o_top, a[2]);
		side = 4'h0;
		st(3, 0, 0);
		rc("top", o_top, a[2]);
		$display("test return stack done");
		m = $random(seed);
		k = $random(seed);
		wr(o_mode, m);
		wr(o_mask, k);
		rc("mask", o_mask, k);
		@(posedge core_clk);
		ax <= $random(seed);
		ay <= $random(seed);
		op(4'h3, 32'h00000000);
		chk("mode", m & ~k, mode);
		rc("saved", o_sav, m);
		wr(o_mode, k);
		st(4, 1, 0);
		n = $random(seed);
		wr(o_sav, n);
		rc("saved", o_sav, n);
		op(4'h8, 32'h00000000);
		st(5, 1, 0);
		op(4'h4, 32'h00000000);
		chk("restore", {1'b1, n, ax, ay}, rest);
		chk("mode", n, mode);
		@(posedge core_clk);
		cmd <= 4'h6;
		@(posedge core_clk);
		cmd <= 4'h7;
		@(posedge core_clk);
		cmd <= 4'h0;
		@(negedge core_clk);
		chk("push pop", {1'b1, n, ax, ay}, rest);
		for (i = 0; i < 16; i++) op(4'h6, 32'h00000000);
		st(4, 15, 1);
		wr(o_stk, 32'h00800000);
		st(4, 15, 0);
		op(4'h5, 32'h00000000);
		chk("jump pop", 1'b1, rest.valid);
		st(4, 14, 0);
		m = $random(seed);
		op(4'h9, m);
		chk("pc", m[23:0], pc);
		rc("pc read", `SHS_OFF_PC, {8'h00, m[23:0]});
		$display("test status stack done");
		complete_run();
	end
endmodule
`default_nettype wire
